// File: rtl/hbp_pkg.sv
package hbp_pkg;

  localparam logic [1:0] HBP_STYLE_STROBES = 2'h0;
  localparam logic [1:0] HBP_STYLE_DSTROBE = 2'h1;
  localparam logic [1:0] HBP_STYLE_EEPROM  = 2'h2;

  localparam int         HBP_ADDR_W = 10;
  localparam int         HBP_DATA_W = 8;
  localparam int         HBP_MOSI_BIT = 0;
  localparam int         HBP_MISO_BIT = 1;
  localparam int         HBP_SCK_BIT  = 2;

  localparam int         HBP_CLK_PERIOD_NS = 25;
  localparam int         HBP_SCK_HALF_NS   = 100;
  localparam int         HBP_SCK_HALF_CYC  = (HBP_SCK_HALF_NS + HBP_CLK_PERIOD_NS - 1) / HBP_CLK_PERIOD_NS;
  localparam logic [3:0] HBP_SCK_HALF_LAST = 4'(HBP_SCK_HALF_CYC - 1);

  localparam logic [7:0]  HBP_EE_CMD_READ  = 8'h03;
  localparam logic [15:0] HBP_EE_START     = 16'h0000;
  localparam int          HBP_EE_HDR_BITS  = 24;
  localparam int          HBP_EE_BYTES     = 16;
  localparam logic [7:0]  HBP_EE_HDR_LAST  = 8'(HBP_EE_HDR_BITS);
  localparam logic [7:0]  HBP_EE_BIT_LAST  = 8'(HBP_EE_HDR_BITS + 8 * HBP_EE_BYTES - 1);

  localparam logic [7:0] HBP_DATA_RST = 8'h00;
  localparam logic [9:0] HBP_ADDR_RST = 10'h000;

  typedef enum logic [1:0] {
    HBP_EE_IDLE,
    HBP_EE_RUN,
    HBP_EE_DONE
  } hbp_ee_state_type;

endpackage

// File: rtl/hbp_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface hbp_reg_if;
  logic [9:0] addr;
  logic [7:0] wdata;
  logic       wr;
  modport source (output addr, output wdata, output wr);
  modport sink   (input addr, input wdata, input wr);
endinterface
`default_nettype wire

// File: rtl/hbp_eeprom_master.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_eeprom_master
  import hbp_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  input  wire logic        enable_in,
  input  wire logic        serial_clock_phase_in,
  input  wire logic        miso_in,
  output logic             mosi_out,
  output logic             eeprom_serial_clock_out,
  output logic             eeprom_select_n_out,
  output logic             done_out,
  hbp_reg_if.source        boot
);
  import hbp_pkg::*;

  hbp_ee_state_type state;
  logic [3:0]       div;
  logic [7:0]       bit_cnt;
  logic [23:0]      tx;
  logic [7:0]       rx;
  logic             tick;
  logic             rise;
  logic             fall;
  logic             upd;
  logic             smp;
  logic [7:0]       next_byte;

  assign tick      = (state == HBP_EE_RUN) && (div == HBP_SCK_HALF_LAST);
  assign rise      = tick && !eeprom_serial_clock_out;
  assign fall      = tick && eeprom_serial_clock_out;
  assign upd       = serial_clock_phase_in ? rise : fall;
  assign smp       = serial_clock_phase_in ? fall : rise;
  assign next_byte = {rx[6:0], miso_in};
  assign done_out  = (state == HBP_EE_DONE);

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state               <= HBP_EE_IDLE;
      eeprom_select_n_out <= 1'b1;
    end
    else
    begin
      case (state)
        HBP_EE_IDLE:
        begin
          if (enable_in)
          begin
            state               <= HBP_EE_RUN;
            eeprom_select_n_out <= 1'b0;
          end
        end
        HBP_EE_RUN:
        begin
          if (!enable_in || (smp && bit_cnt == HBP_EE_BIT_LAST))
          begin
            state               <= HBP_EE_DONE;
            eeprom_select_n_out <= 1'b1;
          end
        end
        HBP_EE_DONE:
        begin
          if (!enable_in)
            state <= HBP_EE_IDLE;
        end
        default:
        begin
          state               <= HBP_EE_IDLE;
          eeprom_select_n_out <= 1'b1;
        end
      endcase
    end
  end

  // clock idles low between transfers; a last sample on a rising edge is not shown, so no edge trails the frame
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div                     <= 4'h0;
      eeprom_serial_clock_out <= 1'b0;
    end
    else if (state != HBP_EE_RUN)
    begin
      div                     <= 4'h0;
      eeprom_serial_clock_out <= 1'b0;
    end
    else if (tick && !(rise && smp && bit_cnt == HBP_EE_BIT_LAST))
    begin
      div                     <= 4'h0;
      eeprom_serial_clock_out <= !eeprom_serial_clock_out;
    end
    else
      div <= div + 4'h1;
  end

  // low phase must present the first bit before the first rising edge
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      tx       <= 24'h00_0000;
      mosi_out <= 1'b0;
    end
    else if (state == HBP_EE_IDLE && enable_in)
    begin
      if (serial_clock_phase_in)
      begin
        tx       <= {HBP_EE_CMD_READ, HBP_EE_START};
        mosi_out <= 1'b0;
      end
      else
      begin
        tx       <= {HBP_EE_CMD_READ[6:0], HBP_EE_START, 1'b0};
        mosi_out <= HBP_EE_CMD_READ[7];
      end
    end
    else if (upd)
    begin
      mosi_out <= tx[23];
      tx       <= {tx[22:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      bit_cnt    <= 8'h00;
      rx         <= 8'h00;
      boot.wr    <= 1'b0;
      boot.addr  <= HBP_ADDR_RST;
      boot.wdata <= HBP_DATA_RST;
    end
    else
    begin
      boot.wr <= 1'b0;
      if (state == HBP_EE_IDLE)
      begin
        bit_cnt   <= 8'h00;
        boot.addr <= HBP_ADDR_RST;
      end
      else if (smp)
      begin
        rx      <= next_byte;
        bit_cnt <= bit_cnt + 8'h01;
        // msb first; a byte is complete on its eighth sample
        if (bit_cnt >= HBP_EE_HDR_LAST && bit_cnt[2:0] == 3'h7)
        begin
          boot.wr    <= 1'b1;
          boot.wdata <= next_byte;
        end
      end
      if (boot.wr)
        boot.addr <= boot.addr + 10'h001;
    end
  end

endmodule
`default_nettype wire

// File: rtl/hbp_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - data lines released while reset is low, or while select is high outside eeprom style.
// - eeprom select driven low during each master transfer.
// - eeprom data sampled falling when phase high, rising when low.
// - eeprom data changed rising when phase high, falling when low.
// - select must be low to access; strobes ignored while it is high.
// - separate strobes: register contents driven while read and select both low.
// - separate strobes: data written on write strobe rising edge, select held low.
// - interrupt output driven low on any unmasked pending event.
// - interrupt stays asserted until all unmasked pending events are serviced.
// - inactive interrupt drive selected by a global control bit.
// - reset low returns all registers and logic to reset state.
// - strap low: style 00 strobes, 01 data strobe, 10 eeprom, 11 reserved.
module hbp_host_port
  import hbp_pkg::*;
(
  input  wire logic                     core_clk_in,
  input  wire logic                     reset_n_in,
  input  wire logic                     hardware_strap_mode_in,
  input  wire logic [1:0]               host_style_select_in,
  input  wire logic                     serial_clock_phase_in,
  input  wire logic                     select_n_in,
  input  wire logic                     read_or_data_strobe_n_in,
  input  wire logic                     write_n_or_direction_in,
  input  wire logic [hbp_pkg::HBP_ADDR_W-1:0] addr_in,
  input  wire logic [hbp_pkg::HBP_DATA_W-1:0] host_data_lines_in,
  output logic      [hbp_pkg::HBP_DATA_W-1:0] host_data_lines_out,
  output logic      [hbp_pkg::HBP_DATA_W-1:0] host_data_lines_oe_n_out,
  output logic                          eeprom_select_n_out,
  output logic                          boot_done_out,
  output logic      [hbp_pkg::HBP_ADDR_W-1:0] reg_addr_out,
  output logic      [hbp_pkg::HBP_DATA_W-1:0] reg_wdata_out,
  output logic                          reg_wr_out,
  output logic                          reg_rd_out,
  input  wire logic [hbp_pkg::HBP_DATA_W-1:0] reg_rdata_in,
  input  wire logic [hbp_pkg::HBP_DATA_W-1:0] int_pending_in,
  input  wire logic [hbp_pkg::HBP_DATA_W-1:0] int_mask_in,
  input  wire logic                     global_control_one_int_drive_in,
  output logic                          int_n_out,
  output logic                          int_oe_n_out
);
  import hbp_pkg::*;

  hbp_reg_if boot ();

  logic       style_strobes;
  logic       style_dstrobe;
  logic       style_eeprom;
  logic       host_read;
  logic       strobe_prev;
  logic       dir_prev;
  logic       sel_prev;
  logic [7:0] data_prev;
  logic [9:0] addr_prev;
  logic       host_write;
  logic       mosi;
  logic       sck;
  logic       ee_select_n;
  logic [7:0] next_data;
  logic [7:0] next_oe_n;

  // read decode shared by the pin drivers and the register read strobe
  function automatic logic read_active(input logic strobes, input logic dstrobe, input logic sel_n,
                                       input logic rd_n, input logic dir);
    read_active = !sel_n && !rd_n && ((strobes) || (dstrobe && dir));
  endfunction

  // one style decode for every path; reserved code 11 and the strap leave all styles off
  function automatic logic style_on(input logic       strap,
                                    input logic [1:0] style,
                                    input logic [1:0] code);
    style_on = !strap && (style == code);
  endfunction

  assign style_strobes = style_on(hardware_strap_mode_in, host_style_select_in, HBP_STYLE_STROBES);
  assign style_dstrobe = style_on(hardware_strap_mode_in, host_style_select_in, HBP_STYLE_DSTROBE);
  assign style_eeprom  = style_on(hardware_strap_mode_in, host_style_select_in, HBP_STYLE_EEPROM);

  assign host_read = read_active(style_strobes, style_dstrobe, select_n_in,
                                 read_or_data_strobe_n_in, write_n_or_direction_in);

  // write lands on the strobe's rising edge using the last sampled data and address;
  // select must still have been low in the cycle before the edge
  assign host_write = !sel_prev &&
                      ((style_strobes && !strobe_prev && write_n_or_direction_in) ||
                       (style_dstrobe && !strobe_prev && read_or_data_strobe_n_in && !dir_prev));

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      strobe_prev <= 1'b1;
      dir_prev    <= 1'b1;
      sel_prev    <= 1'b1;
      data_prev   <= HBP_DATA_RST;
      addr_prev   <= HBP_ADDR_RST;
    end
    else
    begin
      strobe_prev <= style_strobes ? write_n_or_direction_in : read_or_data_strobe_n_in;
      dir_prev    <= write_n_or_direction_in;
      sel_prev    <= select_n_in;
      data_prev   <= host_data_lines_in;
      addr_prev   <= addr_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      reg_addr_out  <= HBP_ADDR_RST;
      reg_wdata_out <= HBP_DATA_RST;
      reg_wr_out    <= 1'b0;
      reg_rd_out    <= 1'b0;
    end
    else if (style_eeprom)
    begin
      reg_wr_out    <= boot.wr;
      reg_rd_out    <= 1'b0;
      reg_addr_out  <= boot.addr;
      reg_wdata_out <= boot.wdata;
    end
    else
    begin
      reg_wr_out    <= host_write;
      reg_rd_out    <= host_read;
      reg_addr_out  <= host_write ? addr_prev : addr_in;
      reg_wdata_out <= host_write ? data_prev : reg_wdata_out;
    end
  end

  hbp_eeprom_master u_eeprom (
    .core_clk_in             (core_clk_in),
    .reset_n_in              (reset_n_in),
    .enable_in               (style_eeprom),
    .serial_clock_phase_in   (serial_clock_phase_in),
    .miso_in                 (host_data_lines_in[HBP_MISO_BIT]),
    .mosi_out                (mosi),
    .eeprom_serial_clock_out (sck),
    .eeprom_select_n_out     (ee_select_n),
    .done_out                (boot_done_out),
    .boot                    (boot)
  );

  // every pin decodes its own role; in eeprom style only the mosi and clock pins are driven, the miso pin stays released
  generate
    for (genvar pin = 0; pin < HBP_DATA_W; pin++)
    begin : g_pin
      if (pin == HBP_MOSI_BIT)
      begin : g_mosi
        assign next_data[pin] = style_eeprom ? mosi : reg_rdata_in[pin];
        assign next_oe_n[pin] = style_eeprom ? 1'b0 : !host_read;
      end
      else if (pin == HBP_SCK_BIT)
      begin : g_sck
        assign next_data[pin] = style_eeprom ? sck : reg_rdata_in[pin];
        assign next_oe_n[pin] = style_eeprom ? 1'b0 : !host_read;
      end
      else
      begin : g_plain
        assign next_data[pin] = style_eeprom ? HBP_DATA_RST[pin] : reg_rdata_in[pin];
        assign next_oe_n[pin] = style_eeprom || !host_read;
      end
    end
  endgenerate

  // data is registered; the enable is cut at once so reset, or select outside eeprom style, releases the bus immediately
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      host_data_lines_out <= HBP_DATA_RST;
    else
      host_data_lines_out <= next_data;
  end

  always_comb
  begin
    if (!reset_n_in || (select_n_in && !style_eeprom))
      host_data_lines_oe_n_out = {HBP_DATA_W{1'b1}};
    else
      host_data_lines_oe_n_out = next_oe_n;
  end

  // the serial pins leave through the pin register, so the select follows a cycle later to stay aligned
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      eeprom_select_n_out <= 1'b1;
    else
      eeprom_select_n_out <= ee_select_n;
  end

  // pending bits are held by the register file until serviced, so the level follows them
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      int_n_out    <= 1'b1;
      int_oe_n_out <= 1'b1;
    end
    else if (|(int_pending_in & int_mask_in))
    begin
      int_n_out    <= 1'b0;
      int_oe_n_out <= 1'b0;
    end
    else
    begin
      int_n_out    <= 1'b1;
      int_oe_n_out <= !global_control_one_int_drive_in;
    end
  end

endmodule
`default_nettype wire

// File: test/hbp_host_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_assertions
  import hbp_pkg::*;
(
  input wire logic       core_clk_in,
  input wire logic       reset_n_in,
  input wire logic       hardware_strap_mode_in,
  input wire logic [1:0] host_style_select_in,
  input wire logic       select_n_in,
  input wire logic       read_or_data_strobe_n_in,
  input wire logic       write_n_or_direction_in,
  input wire logic [9:0] addr_in,
  input wire logic [7:0] host_data_lines_in,
  input wire logic [7:0] host_data_lines_out,
  input wire logic [7:0] host_data_lines_oe_n_out,
  input wire logic [9:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic       reg_wr_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic [7:0] int_pending_in,
  input wire logic [7:0] int_mask_in,
  input wire logic       global_control_one_int_drive_in,
  input wire logic       int_n_out,
  input wire logic       int_oe_n_out
);
  wire logic sep = !hardware_strap_mode_in && host_style_select_in == HBP_STYLE_STROBES;
  wire logic dst = !hardware_strap_mode_in && host_style_select_in == HBP_STYLE_DSTROBE;
  wire logic ee  = !hardware_strap_mode_in && host_style_select_in == HBP_STYLE_EEPROM;
  wire logic rd  = !select_n_in && !read_or_data_strobe_n_in && (sep || dst && write_n_or_direction_in);
  wire logic irq = |(int_pending_in & int_mask_in);
  default clocking dc @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_read;
    rd [*2];
  endsequence
  sequence s_strobe_write;
    sep && !$past(select_n_in) && $rose(write_n_or_direction_in);
  endsequence
  sequence s_ds_write;
    dst && !$past(select_n_in) && !$past(write_n_or_direction_in) && $rose(read_or_data_strobe_n_in);
  endsequence
  AST_RELEASE: assert property (select_n_in && !ee |-> host_data_lines_oe_n_out == 8'hFF)
    else $error("data lines driven while deselected");
  AST_READ_DRIVE: assert property (rd |-> host_data_lines_oe_n_out == 8'h00)
    else $error("read cycle not driving data lines");
  AST_READ_DATA: assert property (s_read |-> host_data_lines_out == $past(reg_rdata_in))
    else $error("read data not from register");
  AST_WRITE: assert property (s_strobe_write |=> reg_wr_out
    && reg_wdata_out == $past(host_data_lines_in, 2) && reg_addr_out == $past(addr_in, 2))
    else $error("strobe write not captured");
  AST_DS_WRITE: assert property (s_ds_write |=> reg_wr_out
    && reg_wdata_out == $past(host_data_lines_in, 2))
    else $error("data strobe write not captured");
  AST_INT_SET: assert property (irq |=> !int_n_out && !int_oe_n_out)
    else $error("interrupt not asserted");
  AST_INT_CLEAR: assert property (!irq |=> int_n_out)
    else $error("interrupt held without pending event");
  AST_INT_IDLE: assert property (!irq |=> int_oe_n_out == !$past(global_control_one_int_drive_in))
    else $error("inactive interrupt drive wrong");
endmodule
bind hbp_host_port hbp_host_port_assertions i_chk (
  .core_clk_in                     (core_clk_in),
  .reset_n_in                      (reset_n_in),
  .hardware_strap_mode_in          (hardware_strap_mode_in),
  .host_style_select_in            (host_style_select_in),
  .select_n_in                     (select_n_in),
  .read_or_data_strobe_n_in        (read_or_data_strobe_n_in),
  .write_n_or_direction_in         (write_n_or_direction_in),
  .addr_in                         (addr_in),
  .host_data_lines_in              (host_data_lines_in),
  .host_data_lines_out             (host_data_lines_out),
  .host_data_lines_oe_n_out        (host_data_lines_oe_n_out),
  .reg_addr_out                    (reg_addr_out),
  .reg_wdata_out                   (reg_wdata_out),
  .reg_wr_out                      (reg_wr_out),
  .reg_rdata_in                    (reg_rdata_in),
  .int_pending_in                  (int_pending_in),
  .int_mask_in                     (int_mask_in),
  .global_control_one_int_drive_in (global_control_one_int_drive_in),
  .int_n_out                       (int_n_out),
  .int_oe_n_out                    (int_oe_n_out)
);
`default_nettype wire

// File: test/hbp_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module hbp_eeprom_model
  import hbp_pkg::*;
(
  input  wire logic        sel_n_in,
  input  wire logic        sck_in,
  input  wire logic        mosi_in,
  input  wire logic        phase_in,
  output var  logic        miso_out,
  output var  logic [23:0] hdr_out
);
  int         n;
  int         j;
  logic [7:0] v;
  initial
    miso_out = 1'b0;
  // no pull on the line, so it wanders while released
  always @(sel_n_in)
  begin
    if (sel_n_in === 1'b0)
      hdr_out = 24'h00_0000;
    n = 0;
    miso_out = ~miso_out;
  end
  always @(sck_in)
  begin
    if (sel_n_in === 1'b0 && sck_in !== phase_in) // sample opposite the device change edge
    begin
      if (n < HBP_EE_HDR_BITS)
        hdr_out = {hdr_out[22:0], mosi_in};
      n++;
    end
    else if (sel_n_in === 1'b0) // change ahead of the device sample edge
    begin
      j = n - HBP_EE_HDR_BITS;
      v = {4'(j / 8), ~4'(j / 8)};
      miso_out = j < 0 ? ~miso_out : v[7 - j % 8];
    end
  end
endmodule
`default_nettype wire

// File: test/hbp_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module hbp_host_port_tb_top;
  import hbp_pkg::*;
  logic        core_clk_in, reset_n_in, strap, phase, sel, rdn, wdn, miso;
  logic        eeprom_select_n_out, boot_done_out, reg_wr_out, reg_rd_out, int_n_out, int_oe_n_out;
  logic        global_control_one_int_drive_in;
  logic [1:0]  style;
  logic [9:0]  addr, reg_addr_out;
  logic [7:0]  hdrv, din, rdata, host_data_lines_out, host_data_lines_oe_n_out, reg_wdata_out;
  logic [7:0]  int_pending_in, int_mask_in;
  logic [23:0] hdr;
  int          n_mismatch, cmp_count;
  assign din = style == HBP_STYLE_EEPROM ? {host_data_lines_out[7:2], miso, host_data_lines_out[0]} : hdrv;
  hbp_host_port i_dut (
    .hardware_strap_mode_in   (strap),
    .host_style_select_in     (style),
    .serial_clock_phase_in    (phase),
    .select_n_in              (sel),
    .read_or_data_strobe_n_in (rdn),
    .write_n_or_direction_in  (wdn),
    .addr_in                  (addr),
    .host_data_lines_in       (din),
    .reg_rdata_in             (rdata),
    .core_clk_in              (core_clk_in),
    .reset_n_in               (reset_n_in),
    .host_data_lines_out      (host_data_lines_out),
    .host_data_lines_oe_n_out (host_data_lines_oe_n_out),
    .eeprom_select_n_out      (eeprom_select_n_out),
    .boot_done_out            (boot_done_out),
    .reg_addr_out             (reg_addr_out),
    .reg_wdata_out            (reg_wdata_out),
    .reg_wr_out               (reg_wr_out),
    .reg_rd_out               (reg_rd_out),
    .int_pending_in           (int_pending_in),
    .int_mask_in              (int_mask_in),
    .global_control_one_int_drive_in (global_control_one_int_drive_in),
    .int_n_out                (int_n_out),
    .int_oe_n_out             (int_oe_n_out)
  );
  hbp_eeprom_model i_ee (
    .sel_n_in (eeprom_select_n_out),
    .sck_in   (host_data_lines_out[HBP_SCK_BIT]),
    .mosi_in  (host_data_lines_out[HBP_MOSI_BIT]),
    .phase_in (phase),
    .miso_out (miso),
    .hdr_out  (hdr)
  );
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #2;
  endtask
  task automatic done(input string t);
    $display("test %s done, mismatches %0d", t, n_mismatch);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset;
    reset_n_in = 0;
    step(4); // clock already running
    `CHK("rst_oe", 8'hFF, host_data_lines_oe_n_out)
    `CHK("rst_int", 2'h3, {int_n_out, int_oe_n_out})
    `CHK("rst_ee", 2'h2, {eeprom_select_n_out, reg_wr_out})
    reset_n_in = 1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic ds, input logic s);
    logic got;
    got = 0;
    sel = s;
    addr = a;
    hdrv = d;
    wdn = 0;
    rdn = !ds;
    step(1);
    if (ds)
      rdn = 1;
    else
      wdn = 1;
    repeat (4)
    begin
      step(1);
      if (reg_wr_out === 1'b1)
      begin
        got = 1;
        `CHK("wr_addr", a, reg_addr_out)
        `CHK("wr_data", d, reg_wdata_out)
      end
    end
    `CHK("wr_taken", !s && !strap && !style[1], got)
    sel = 1;
    wdn = 1;
    step(1);
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] d, input logic s);
    logic ok;
    ok = !s && !strap && !style[1];
    sel = s;
    addr = a;
    rdata = d;
    hdrv = ~d;
    rdn = 0;
    wdn = 1;
    step(3);
    `CHK("rd_oe", ok ? 8'h00 : 8'hFF, host_data_lines_oe_n_out)
    if (ok)
    begin
      `CHK("rd_data", d, host_data_lines_out)
      `CHK("rd_addr", a, reg_addr_out)
    end
    `CHK("rd_strobe", ok, reg_rd_out)
    sel = 1;
    rdn = 1;
    step(1);
    `CHK("rd_off", 8'hFF, host_data_lines_oe_n_out)
  endtask
  task automatic irq(input logic [7:0] p, input logic [7:0] m, input logic g, input logic en, input logic eo);
    int_pending_in = p;
    int_mask_in = m;
    global_control_one_int_drive_in = g;
    step(2);
    `CHK("int_n", en, int_n_out)
    `CHK("int_oe_n", eo, int_oe_n_out)
  endtask
  task automatic ee_load(input logic ph);
    int nb;
    nb = 0;
    style = HBP_STYLE_EEPROM;
    phase = ph;
    do_reset();
    for (int c = 0; c < 1400; c++)
    begin
      step(1);
      if (c == 100)
        `CHK("ee_sel", 1'b0, eeprom_select_n_out)
      if (reg_wr_out === 1'b1)
      begin
        `CHK("ee_addr", 10'(nb), reg_addr_out)
        `CHK("ee_data", {4'(nb), ~4'(nb)}, reg_wdata_out)
        nb++;
      end
    end
    `CHK("ee_hdr", {HBP_EE_CMD_READ, HBP_EE_START}, hdr)
    `CHK("ee_bytes", HBP_EE_BYTES, nb)
    `CHK("ee_end", 2'h3, {boot_done_out, eeprom_select_n_out})
    done("eeprom");
  endtask
  initial
  begin
    core_clk_in = 0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end
  // two loads of about 1400 cycles dominate the run
  initial
  begin
    repeat (6000) @(posedge core_clk_in);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    {strap, sel, rdn, wdn, phase} = 5'h0F;
    {n_mismatch, cmp_count} = 0;
    {style, addr, hdrv, rdata} = 28'h000_0000;
    {int_pending_in, int_mask_in, global_control_one_int_drive_in} = 17'h0_0000;
    do_reset();
    wr(10'h3FF, 8'hA5, 0, 0);
    wr(10'h155, 8'h5A, 0, 1);
    rd(10'h3FF, 8'h3C, 0);
    rd(10'h200, 8'hC3, 1);
    done("strobes");
    style = HBP_STYLE_DSTROBE;
    wr(10'h2AA, 8'h96, 1, 0);
    wr(10'h0F0, 8'h69, 1, 1);
    rd(10'h001, 8'hF0, 0);
    done("data strobe");
    style = 2'h3;
    rd(10'h001, 8'h0F, 0);
    style = HBP_STYLE_STROBES;
    strap = 1;
    wr(10'h002, 8'h11, 0, 0);
    strap = 0;
    done("idle modes");
    irq(8'h04, 8'h00, 1, 1, 0);
    irq(8'h04, 8'h04, 1, 0, 0);
    irq(8'h84, 8'h80, 0, 0, 0);
    irq(8'h00, 8'h80, 0, 1, 1);
    done("interrupt");
    ee_load(1'b1);
    ee_load(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
